/* hdl/dsprst_pkg.sv */
// constants shared by the display reset sequencer
// What this block does
// - reset clears counters, character, flash, control
// - three clearing clocks; sequence ends seven display clocks after release
// - every character location gets code 20h
// - flash bits and control word become zero
// - user glyph memory and address kept
// - flash timing divides display clock by 28672
// - bit 3 flash enable, bit 4 blink overrides
package dsprst_pkg;
    localparam int DSPRST_DIGITS = 8;
    localparam logic [7:0] DSPRST_BLANK_CODE = 8'h20;
    localparam logic [7:0] DSPRST_CTRL_RESET = 8'h00;
    localparam int DSPRST_FLASH_BIT = 3;
    localparam int DSPRST_BLINK_BIT = 4;
    localparam logic [1:0] DSPRST_SEQ_CYCLES = 2'h3;
    localparam logic [14:0] DSPRST_FLASH_DIV = 15'h7000;
    localparam int DSPRST_MIN_US = 110;
    typedef enum logic [2:0] {
        DSPRST_READY = 3'b001,
        DSPRST_HELD = 3'b010,
        DSPRST_CLEAR = 3'b100
    } dsprst_state_type;
endpackage : dsprst_pkg

/* hdl/dsprst_sequencer.sv */
// display reset sequencer with memories and flash timing
`timescale 1ns/10ps
module dsprst_sequencer #(
    parameter int DIGITS = dsprst_pkg::DSPRST_DIGITS
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RESET_N,
    input wire logic WR_EN,
    input wire logic [1:0] WR_SEL,
    input wire logic [2:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    output logic BUSY,
    output logic [8*DIGITS-1:0] CHAR_MEM,
    output logic [DIGITS-1:0] FLASH_MEM,
    output logic [7:0] CTRL_WORD,
    output logic [3:0] GLYPH_ADDR,
    output logic [35*16-1:0] GLYPH_MEM,
    output logic [DIGITS-1:0] DIGIT_ON,
    output logic PHASE
);
    // write select codes: 0 char, 1 flash, 2 control, 3 glyph address
    typedef struct packed {
        dsprst_pkg::dsprst_state_type st;
        logic [1:0] cnt;
        logic [2:0] rsync;
        logic [14:0] div;
        logic phase;
        logic [8*DIGITS-1:0] chr;
        logic [DIGITS-1:0] fl;
        logic [7:0] ctl;
        logic [3:0] gaddr;
        logic [35*16-1:0] glyph;
    } dsprst_regs_type;
    dsprst_regs_type r_q, r_d;
    logic held;
    // reset pin synchronised; level taken when stages two and three agree
    assign held = (r_q.rsync[1] == r_q.rsync[2]) ? ~r_q.rsync[2]
                  : (r_q.st == dsprst_pkg::DSPRST_HELD);
    always_comb begin
        r_d = r_q;
        r_d.rsync = {r_q.rsync[1:0], RESET_N};
        // flash timebase free-running except in HELD, where it is held at zero
        if (r_q.div == dsprst_pkg::DSPRST_FLASH_DIV - 15'h0001) begin
            r_d.div = 15'h0000;
            r_d.phase = ~r_q.phase;
        end else begin
            r_d.div = r_q.div + 15'h0001;
        end
        case (r_q.st)
            dsprst_pkg::DSPRST_READY: begin
                if (held) begin
                    r_d.st = dsprst_pkg::DSPRST_HELD;
                end else if (WR_EN) begin
                    case (WR_SEL)
                        2'd0: r_d.chr[WR_ADDR*8 +: 8] = WR_DATA;
                        2'd1: r_d.fl[WR_ADDR] = WR_DATA[0];
                        2'd2: r_d.ctl = WR_DATA;
                        default: r_d.gaddr = WR_DATA[3:0];
                    endcase
                end
            end
            dsprst_pkg::DSPRST_HELD: begin
                // pending while low; counters held at start, aligns blink
                r_d.div = 15'h0000;
                r_d.phase = 1'b0;
                r_d.cnt = 2'h0;
                if (!held) begin
                    r_d.st = dsprst_pkg::DSPRST_CLEAR;
                end
            end
            dsprst_pkg::DSPRST_CLEAR: begin
                for (int i = 0; i < DIGITS; i++) begin
                    r_d.chr[i*8 +: 8] = dsprst_pkg::DSPRST_BLANK_CODE;
                end
                r_d.fl = '0;
                r_d.ctl = dsprst_pkg::DSPRST_CTRL_RESET;
                r_d.cnt = r_q.cnt + 2'h1;
                if (held) begin
                    r_d.st = dsprst_pkg::DSPRST_HELD;
                end else if (r_q.cnt == dsprst_pkg::DSPRST_SEQ_CYCLES - 2'h1)
                begin
                    r_d.st = dsprst_pkg::DSPRST_READY;
                end
            end
            default: r_d.st = dsprst_pkg::DSPRST_HELD;
        endcase
        // glyph memory and address untouched by reset path
    end
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            r_q.st <= dsprst_pkg::DSPRST_HELD;
            r_q.cnt <= 2'h0;
            r_q.rsync <= 3'b000;
            r_q.div <= 15'h0000;
            r_q.phase <= 1'b0;
            r_q.chr <= '0;
            r_q.fl <= '0;
            r_q.ctl <= 8'h00;
            r_q.gaddr <= 4'h0;
            r_q.glyph <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    // display gating: blink overrides per-digit flash
    always_comb begin
        for (int i = 0; i < DIGITS; i++) begin
            if (r_q.ctl[dsprst_pkg::DSPRST_BLINK_BIT]) begin
                DIGIT_ON[i] = ~r_q.phase;
            end else if (r_q.ctl[dsprst_pkg::DSPRST_FLASH_BIT] && r_q.fl[i])
            begin
                DIGIT_ON[i] = ~r_q.phase;
            end else begin
                DIGIT_ON[i] = 1'b1;
            end
        end
    end
    assign BUSY = (r_q.st != dsprst_pkg::DSPRST_READY);
    assign CHAR_MEM = r_q.chr;
    assign FLASH_MEM = r_q.fl;
    assign CTRL_WORD = r_q.ctl;
    assign GLYPH_ADDR = r_q.gaddr;
    assign GLYPH_MEM = r_q.glyph;
    assign PHASE = r_q.phase;

    property p_clear_len;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.st == dsprst_pkg::DSPRST_HELD && r_d.st ==
         dsprst_pkg::DSPRST_CLEAR) |=> (BUSY && !held) [*3] ##1 !BUSY;
    endproperty
    a_clear_len: assert property (p_clear_len)
        else $error("reset sequence length wrong");

    property p_blank;
        @(posedge REF_CLK) disable iff (RST)
        $fell(BUSY) |-> CHAR_MEM[7:0] == dsprst_pkg::DSPRST_BLANK_CODE
            && FLASH_MEM == '0 && CTRL_WORD == 8'h00;
    endproperty
    a_blank: assert property (p_blank)
        else $error("memories not cleared by reset");

    property p_keep;
        @(posedge REF_CLK) disable iff (RST)
        BUSY |=> $stable(GLYPH_ADDR);
    endproperty
    a_keep: assert property (p_keep)
        else $error("glyph address changed during reset");

    property p_ignore;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.st == dsprst_pkg::DSPRST_HELD) |=> PHASE == 1'b0
            && CTRL_WORD == $past(CTRL_WORD);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("state moved while reset held");

    // memories frozen while the pin keeps the sequence pending
    property p_hold_mem;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.st == dsprst_pkg::DSPRST_HELD) |=> $stable(CHAR_MEM)
            && $stable(FLASH_MEM);
    endproperty
    a_hold_mem: assert property (p_hold_mem)
        else $error("memory changed while reset held");

    // counters parked at their start value while reset held
    property p_counters;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.st == dsprst_pkg::DSPRST_HELD) |=> r_q.div == 15'h0000
            && r_q.cnt == 2'h0;
    endproperty
    a_counters: assert property (p_counters)
        else $error("timing counters not cleared by reset");

    // every clearing cycle leaves blanks and no flash bits
    property p_clear_fill;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.st == dsprst_pkg::DSPRST_CLEAR) |=> CHAR_MEM ==
            {DIGITS{dsprst_pkg::DSPRST_BLANK_CODE}} && FLASH_MEM == '0;
    endproperty
    a_clear_fill: assert property (p_clear_fill)
        else $error("clearing cycle did not blank memories");

    // divider never leaves its range
    property p_div_range;
        @(posedge REF_CLK) disable iff (RST)
        r_q.div < dsprst_pkg::DSPRST_FLASH_DIV;
    endproperty
    a_div_range: assert property (p_div_range)
        else $error("flash divider out of range");

    // phase flips when the divider wraps
    property p_phase_flip;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.div == dsprst_pkg::DSPRST_FLASH_DIV - 15'h0001
            && r_q.st != dsprst_pkg::DSPRST_HELD) |=> PHASE != $past(PHASE);
    endproperty
    a_phase_flip: assert property (p_phase_flip)
        else $error("flash phase did not toggle at wrap");

    // phase holds between wraps
    property p_phase_steady;
        @(posedge REF_CLK) disable iff (RST)
        (r_q.div != dsprst_pkg::DSPRST_FLASH_DIV - 15'h0001
            && r_q.st != dsprst_pkg::DSPRST_HELD) |=> $stable(PHASE);
    endproperty
    a_phase_steady: assert property (p_phase_steady)
        else $error("flash phase toggled early");

    // blink drives all digits from the phase
    property p_blink_all;
        @(posedge REF_CLK) disable iff (RST)
        CTRL_WORD[dsprst_pkg::DSPRST_BLINK_BIT] |-> DIGIT_ON ==
            {DIGITS{~PHASE}};
    endproperty
    a_blink_all: assert property (p_blink_all)
        else $error("blink did not override digits");

    // with both bits clear every digit stays lit
    property p_flash_off;
        @(posedge REF_CLK) disable iff (RST)
        (!CTRL_WORD[dsprst_pkg::DSPRST_BLINK_BIT]
            && !CTRL_WORD[dsprst_pkg::DSPRST_FLASH_BIT]) |->
            DIGIT_ON == {DIGITS{1'b1}};
    endproperty
    a_flash_off: assert property (p_flash_off)
        else $error("digit dark with flash and blink off");

    // glyph storage untouched by the reset sequence
    property p_glyph_keep;
        @(posedge REF_CLK) disable iff (RST)
        BUSY |=> $stable(GLYPH_MEM);
    endproperty
    a_glyph_keep: assert property (p_glyph_keep)
        else $error("glyph memory changed during reset");
endmodule // dsprst_sequencer

/* tb/dsprst_host.sv */
// host model driving the reset pin and the write bus
`timescale 1ns/10ps
module dsprst_host (
    input wire logic ref_clk,
    output logic reset_n,
    output logic wr_en,
    output logic [1:0] wr_sel,
    output logic [2:0] wr_addr,
    output logic [7:0] wr_data
);
    // idle bus at time zero
    initial begin
        reset_n = 1'b1;
        wr_en = 1'b0;
        {wr_sel, wr_addr, wr_data} = '0;
    end
    // hold the pin low for n cycles, released at one moment
    task automatic pin_reset(input int n);
        @(negedge ref_clk) reset_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        reset_n = 1'b1;
    endtask
    // one write, held across one rising edge
    task automatic write(input logic [1:0] s, input logic [2:0] a,
                         input logic [7:0] d);
        @(negedge ref_clk);
        {wr_en, wr_sel, wr_addr, wr_data} = {1'b1, s, a, d};
        @(negedge ref_clk);
        wr_en = 1'b0;
        wr_data = ~d; // a released bus keeps no stale value
    endtask
endmodule // dsprst_host

/* tb/dsprst_sequencer_bench.sv */
// self-checking bench for the display reset sequencer
`timescale 1ns/10ps
module dsprst_sequencer_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic busy, phase, reset_n, wr_en;
    logic [1:0] wr_sel;
    logic [2:0] wr_addr;
    logic [7:0] wr_data, ctrl_word, flash_mem, digit_on;
    logic [63:0] char_mem;
    logic [3:0] glyph_addr;
    logic [31:0] r = 32'hc0fa;
    int errors = 0;
    int n_tests = 0;
    int n;
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    dsprst_host dsprst_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .wr_en(wr_en), .wr_sel(wr_sel), .wr_addr(wr_addr),
        .wr_data(wr_data));
    dsprst_sequencer dsprst_sequencer_i (.REF_CLK(ref_clk), .RST(rst),
        .RESET_N(reset_n), .WR_EN(wr_en), .WR_SEL(wr_sel),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(busy),
        .CHAR_MEM(char_mem), .FLASH_MEM(flash_mem), .CTRL_WORD(ctrl_word),
        .GLYPH_ADDR(glyph_addr), .GLYPH_MEM(), .DIGIT_ON(digit_on),
        .PHASE(phase));
    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t value mismatch", $time);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one bounded cycle of waiting
    task automatic tick(inout int k, input int lim);
        @(negedge ref_clk);
        k++;
        if (k < lim) return;
        errors++;
        print_verdict();
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        n = 0;
        while (busy !== 1'b0) tick(n, 20);
        dsprst_host_i.write(2'h3, 3'h0, 8'h0a);
        dsprst_host_i.write(2'h2, 3'h0, 8'h18);
        dsprst_host_i.write(2'h1, 3'h5, 8'h01);
        check(ctrl_word, 64'h18);
        dsprst_host_i.pin_reset(5);
        check(busy, 64'h1);
        dsprst_host_i.write(2'h0, 3'h2, 8'h41);
        n = 0;
        while (busy !== 1'b0) tick(n, 9);
        check(char_mem, {8{8'h20}});
        check({flash_mem, ctrl_word}, 64'h0);
        check(glyph_addr, 64'ha);
        check({digit_on, phase}, 64'h1fe);
        for (int i = 0; i < 16; i++) begin
            r = xs(r);
            dsprst_host_i.write(2'h0, r[2:0], r[15:8]);
            check(char_mem[8*r[2:0] +: 8], r[15:8]);
        end
        n = 0;
        while (phase === 1'b0) tick(n, 30000);
        n = 0;
        while (phase === 1'b1) tick(n, 30000);
        check(n, 64'd28672);
        n = 0;
        while (phase === 1'b0) tick(n, 30000);
        dsprst_host_i.write(2'h1, 3'h5, 8'h01);
        dsprst_host_i.write(2'h2, 3'h0, 8'h08);
        check(digit_on, {2'b11, ~phase, 5'h1f});
        dsprst_host_i.write(2'h2, 3'h0, 8'h18);
        check(digit_on, {8{~phase}});
        print_verdict();
    end
endmodule // dsprst_sequencer_bench
